// ==== verilog/scl_strap_config_latch.sv ====
// strap sampling and decode of power-up configuration
`timescale 1ns/1ps
module scl_strap_config_latch
	import scl_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic reset_in,
	input wire logic reset_pin_n_in,
	input wire logic power_up_done_in,
	input wire logic soft_reset_done_in,
	input wire logic power_down_exit_in,
	input wire logic start_bit_in,
	input wire logic [11:0] strap_pins_in,
	output logic chip_reset_out,
	output logic forward_enable_out,
	output logic inband_management_out,
	output logic [1:0] xmii_mode_out,
	output logic xmii_reserved_out,
	output logic mii_mac_mode_out,
	output logic ref_clock_out_en_out,
	output logic ref_clock_in_sel_out,
	output logic inband_link_status_out,
	output logic speed_1000_out,
	output logic [1:0] serial_mode_out,
	output logic [1:0] phy_config_out,
	output logic phy_aneg_out,
	output logic phy_force_mdi_out,
	output logic phy_reserved_out,
	output logic factory_test_out,
	output logic capture_out
);
	typedef struct packed {
		logic [11:0] pins_meta;
		logic [11:0] pins_sync;
		logic [2:0] ev_meta;
		logic [2:0] ev_sync;
		logic [2:0] ev_prev;
		logic rst_meta;
		logic rst_sync;
		logic rst_prev;
		logic [12:0] straps;
		logic start_seen;
		logic capture;
		logic chip_reset;
		logic forward_enable;
		logic inband;
		logic [1:0] xmii;
		logic xmii_rsvd;
		logic mii_mac;
		logic refclk_out;
		logic refclk_in;
		logic inband_link_status;
		logic speed_1000;
		logic [1:0] ser;
		logic [1:0] phy;
		logic aneg;
		logic force_mdi;
		logic phy_rsvd;
		logic ftest;
	} scl_state_t;

	scl_state_t st;
	scl_state_t next_st;

	function automatic logic [1:0] scl_ser_decode(input logic [1:0] code);
		if (code[1]) begin
			scl_ser_decode = SER_SPI;
		end else begin
			scl_ser_decode = code;
		end
	endfunction

	always_comb begin
		logic [2:0] ev_rise;
		logic [12:0] s;
		logic fire;
		ev_rise = 3'h0;
		s = 13'h0000;
		fire = 1'b0;
		next_st = st;
		// two-flop synchronisers; the second stage is read, and events and reset pin add a third flop for edge detection
		next_st.pins_meta = strap_pins_in;
		next_st.pins_sync = st.pins_meta;
		next_st.ev_meta = {power_down_exit_in, soft_reset_done_in, power_up_done_in};
		next_st.ev_sync = st.ev_meta;
		next_st.ev_prev = st.ev_sync;
		next_st.rst_meta = reset_pin_n_in;
		next_st.rst_sync = st.rst_meta;
		next_st.rst_prev = st.rst_sync;
		ev_rise = st.ev_sync & ~st.ev_prev;
		next_st.chip_reset = ~st.rst_sync;
		fire = (|ev_rise) | (st.rst_sync & ~st.rst_prev);
		if (fire) begin
			next_st.straps = {1'b0, st.pins_sync};
			next_st.start_seen = 1'b0;
		end // otherwise straps hold
		next_st.capture = fire;
		// start bit latches so a short pulse still releases forwarding
		if (start_bit_in) begin
			next_st.start_seen = 1'b1;
		end
		s = next_st.straps;
		next_st.forward_enable = ~next_st.chip_reset &
			(s[POS_START_FWD] | next_st.start_seen);
		next_st.inband = ~s[POS_INBAND];
		next_st.xmii = {s[POS_XMII_HI], s[POS_XMII_LO]};
		next_st.xmii_rsvd = (next_st.xmii == XMII_RSVD);
		next_st.mii_mac = (next_st.xmii == XMII_MII) & s[POS_P3_MODE];
		next_st.refclk_out = (next_st.xmii == XMII_RMII) & ~s[POS_P3_MODE];
		next_st.refclk_in = (next_st.xmii == XMII_RMII) & s[POS_P3_MODE];
		next_st.inband_link_status = (next_st.xmii == XMII_RGMII) & s[POS_P3_MODE];
		next_st.speed_1000 = ~s[POS_P3_SPEED];
		next_st.ser = scl_ser_decode({s[POS_SER_HI], s[POS_SER_LO]});
		next_st.phy = {s[POS_RX_ERR], s[POS_WAKE]};
		next_st.aneg = (next_st.phy == PHY_ANEG_EEE);
		next_st.force_mdi = (next_st.phy == PHY_FORCE_MDI);
		next_st.phy_rsvd = (next_st.phy == PHY_RSVD);
		next_st.ftest = s[POS_TEST_A] | s[POS_TEST_B];
	end

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			st <= '0;
			st.straps <= STRAP_RESET;
			st.rst_meta <= 1'b1;
			st.rst_sync <= 1'b1;
			st.rst_prev <= 1'b1;
			st.inband <= 1'b0;
			st.mii_mac <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign chip_reset_out = st.chip_reset;
	assign forward_enable_out = st.forward_enable;
	assign inband_management_out = st.inband;
	assign xmii_mode_out = st.xmii;
	assign xmii_reserved_out = st.xmii_rsvd;
	assign mii_mac_mode_out = st.mii_mac;
	assign ref_clock_out_en_out = st.refclk_out;
	assign ref_clock_in_sel_out = st.refclk_in;
	assign inband_link_status_out = st.inband_link_status;
	assign speed_1000_out = st.speed_1000;
	assign serial_mode_out = st.ser;
	assign phy_config_out = st.phy;
	assign phy_aneg_out = st.aneg;
	assign phy_force_mdi_out = st.force_mdi;
	assign phy_reserved_out = st.phy_rsvd;
	assign factory_test_out = st.ftest;
	assign capture_out = st.capture;

	property p_capture_loads;
		@(posedge ref_clk_in) disable iff (reset_in)
		capture_out |-> st.straps[11:0] == $past(st.pins_sync, 1);
	endproperty
	a_capture_loads: assert property (p_capture_loads) else $error("capture missed pins");

	property p_reset_edge_capture;
		@(posedge ref_clk_in) disable iff (reset_in)
		(st.rst_sync && !st.rst_prev) |=> capture_out;
	endproperty
	a_reset_edge_capture: assert property (p_reset_edge_capture) else $error("no recapture");

	property p_hold;
		@(posedge ref_clk_in) disable iff (reset_in)
		!capture_out |-> $stable(st.straps);
	endproperty
	a_hold: assert property (p_hold) else $error("straps changed without capture");

	property p_forward;
		@(posedge ref_clk_in) disable iff (reset_in)
		(forward_enable_out && !chip_reset_out) |-> (st.straps[POS_START_FWD] || st.start_seen);
	endproperty
	a_forward: assert property (p_forward) else $error("forwarding without enable");

	property p_inband;
		@(posedge ref_clk_in) disable iff (reset_in)
		##1 inband_management_out == !st.straps[POS_INBAND];
	endproperty
	a_inband: assert property (p_inband) else $error("inband decode wrong");

	property p_refclk;
		@(posedge ref_clk_in) disable iff (reset_in)
		!(ref_clock_out_en_out && ref_clock_in_sel_out);
	endproperty
	a_refclk: assert property (p_refclk) else $error("ref clock both ways");

	property p_speed;
		@(posedge ref_clk_in) disable iff (reset_in)
		##1 speed_1000_out == !st.straps[POS_P3_SPEED];
	endproperty
	a_speed: assert property (p_speed) else $error("speed decode wrong");

	property p_ser;
		@(posedge ref_clk_in) disable iff (reset_in)
		st.straps[POS_SER_HI] |-> serial_mode_out == SER_SPI;
	endproperty
	a_ser: assert property (p_ser) else $error("spi decode wrong");

	property p_phy;
		@(posedge ref_clk_in) disable iff (reset_in)
		phy_aneg_out |-> !phy_force_mdi_out && !phy_reserved_out;
	endproperty
	a_phy: assert property (p_phy) else $error("phy decode overlap");

	property p_chip_reset;
		@(posedge ref_clk_in) disable iff (reset_in)
		!st.rst_sync |=> chip_reset_out && !forward_enable_out;
	endproperty
	a_chip_reset: assert property (p_chip_reset) else $error("reset pin not obeyed");
endmodule

// ==== verilog/scl_pkg.sv ====
// shared constants for the strap configuration latch
package scl_pkg;
	// strap vector bit positions
	localparam int STRAP_W = 13;
	localparam int POS_START_FWD = 0;
	localparam int POS_INBAND = 1;
	localparam int POS_P3_MODE = 2;
	localparam int POS_P3_SPEED = 3;
	localparam int POS_XMII_LO = 4;
	localparam int POS_XMII_HI = 5;
	localparam int POS_SER_LO = 6;
	localparam int POS_SER_HI = 7;
	localparam int POS_WAKE = 8;
	localparam int POS_RX_ERR = 9;
	localparam int POS_TEST_A = 10;
	localparam int POS_TEST_B = 11;
	localparam int POS_SPARE = 12;
	// strap levels assumed before the first capture
	// start forward, in-band off, port-3 MAC side and 100Mbps; all else low
	localparam logic [12:0] STRAP_RESET = 13'h000f;
	localparam logic [1:0] XMII_MII = 2'h0;
	localparam logic [1:0] XMII_RMII = 2'h1;
	localparam logic [1:0] XMII_RSVD = 2'h2;
	localparam logic [1:0] XMII_RGMII = 2'h3;
	localparam logic [1:0] SER_MIIM = 2'h0;
	localparam logic [1:0] SER_I2C = 2'h1;
	localparam logic [1:0] SER_SPI = 2'h2;
	localparam logic [1:0] PHY_RSVD = 2'h0;
	localparam logic [1:0] PHY_ANEG_EEE = 2'h1;
	localparam logic [1:0] PHY_FORCE_MDIX = 2'h2;
	localparam logic [1:0] PHY_FORCE_MDI = 2'h3;
endpackage

// ==== sim/scl_board_model.sv ====
// board strap resistors seen by the latch, set up the way a careful board would
`timescale 1ns/1ps
module scl_board_model (
	input wire logic [11:0] setting_in,
	output logic [11:0] strap_pins_out
);
	always_comb begin
		strap_pins_out = setting_in;
		// factory test is never strapped on a real board
		strap_pins_out[11:10] = 2'h0;
		if (!setting_in[5]) begin
			strap_pins_out[3] = 1'b1;
		end
		if (setting_in[7:6] == 2'h1) begin
			strap_pins_out[1] = 1'b1;
		end
	end
endmodule

// ==== sim/scl_strap_config_latch_bench.sv ====
// self-checking bench for the strap configuration latch
`timescale 1ns/1ps
module scl_strap_config_latch_bench;
	import scl_pkg::*;
	logic ref_clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic rst_n = 1'b1, pwr_up = 1'b0, soft_done = 1'b0, pd_exit = 1'b0, start_bit = 1'b0;
	logic [11:0] setting = 12'h000b;
	logic [11:0] pins;
	logic chip_rst, fwd_en, inband_management, xrsv, mac_mode, rco_en, rci_sel, inband_link_status, spd1000;
	logic aneg, fmdi, prsv, ftest, cap;
	logic [1:0] xmii, ser, phy;
	int err_count = 0;
	int num_checks = 0;
	always #2 ref_clk_in = ~ref_clk_in;
	scl_board_model BOARD (.setting_in(setting), .strap_pins_out(pins));
	scl_strap_config_latch DUT (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
		.reset_pin_n_in(rst_n), .power_up_done_in(pwr_up), .soft_reset_done_in(soft_done),
		.power_down_exit_in(pd_exit), .start_bit_in(start_bit), .strap_pins_in(pins),
		.chip_reset_out(chip_rst), .forward_enable_out(fwd_en), .inband_management_out(inband_management),
		.xmii_mode_out(xmii), .xmii_reserved_out(xrsv), .mii_mac_mode_out(mac_mode),
		.ref_clock_out_en_out(rco_en), .ref_clock_in_sel_out(rci_sel),
		.inband_link_status_out(inband_link_status), .speed_1000_out(spd1000), .serial_mode_out(ser),
		.phy_config_out(phy), .phy_aneg_out(aneg), .phy_force_mdi_out(fmdi),
		.phy_reserved_out(prsv), .factory_test_out(ftest), .capture_out(cap));
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk_in);
		#1;
	endtask
	task automatic check(input logic [3:0] seen, input logic [3:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// raise one capture event (3 = reset pin) and wait for the capture pulse
	task automatic fire(input int k);
		int n;
		tick(4);
		case (k)
			0: pwr_up = 1'b1;
			1: soft_done = 1'b1;
			2: pd_exit = 1'b1;
			default: rst_n = 1'b0;
		endcase
		if (k == 3) begin
			tick(4);
			check(chip_rst, 1'b1);
			check(fwd_en, 1'b0);
			rst_n = 1'b1;
		end
		n = 0;
		while (cap !== 1'b1 && n < 12) begin
			tick(1);
			n++;
		end
		if (n == 12) begin
			err_count++;
			$display("unexpected at %0t: no capture pulse", $time);
			print_verdict();
		end
		tick(1);
		check(cap, 1'b0);
		{pwr_up, soft_done, pd_exit} = 3'h0;
	endtask
	task automatic t_start;
		setting = 12'h0108;
		fire(0);
		check(fwd_en, 1'b0);
		check(inband_management, 1'b1);
		check(mac_mode, 1'b0);
		check(spd1000, 1'b0);
		check(aneg, 1'b1);
		check(ftest, 1'b0);
		start_bit = 1'b1;
		tick(1);
		start_bit = 1'b0;
		tick(3);
		check(fwd_en, 1'b1);
		setting = 12'h010f;
		fire(3);
		check(fwd_en, 1'b1);
		check(inband_management, 1'b0);
		check(mac_mode, 1'b1);
		// pins wander after capture; nothing may follow them
		setting = 12'h03f0;
		tick(8);
		check(inband_management, 1'b0);
		check(xmii, XMII_MII);
		check(phy, PHY_ANEG_EEE);
		$display("test start done");
	endtask
	task automatic t_codes;
		logic [1:0] c;
		for (int i = 0; i < 4; i++) begin
			c = i[1:0];
			setting = {2'b00, c, c, c, 1'b0, c[0], 2'b01};
			fire(i);
			check(xmii, c);
			check(xrsv, c == 2'h2);
			check(ser, c[1] ? SER_SPI : c);
			check(phy, c);
			check({prsv, aneg, fmdi}, {c == 2'h0, c == 2'h1, c == 2'h3});
			check(spd1000, c[1]);
			check(inband_management, c != 2'h1);
			check(fwd_en, 1'b1);
			if (c == 2'h0) check(mac_mode, 1'b0);
			if (c == 2'h1) check({rco_en, rci_sel}, 2'h1);
			if (c == 2'h3) check(inband_link_status, 1'b1);
		end
		$display("test codes done");
	endtask
	task automatic t_port3;
		// rmii with the reference clock driven out
		setting = 12'h0113;
		fire(1);
		check({rco_en, rci_sel}, 2'h2);
		check(mac_mode, 1'b0);
		check(inband_link_status, 1'b0);
		check(spd1000, 1'b0);
		// rgmii with in-band status off at gigabit speed
		setting = 12'h0133;
		fire(2);
		check(inband_link_status, 1'b0);
		check({rco_en, rci_sel}, 2'h0);
		check(spd1000, 1'b1);
		check(inband_management, 1'b0);
		$display("test port3 done");
	endtask
	initial begin
		tick(6);
		reset_in = 1'b0;
		t_start();
		t_codes();
		t_port3();
		print_verdict();
	end
endmodule
